/* verilog/asu_pkg.sv */
package asu_pkg;
  localparam int CLK_HZ = 10000000;
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_C = 4'h9;
  localparam logic [3:0] TX_LAST_PHASE = 4'hf;
  localparam logic [3:0] FRAME_LEN_8 = 4'ha;
  localparam logic [3:0] FRAME_LEN_9 = 4'hb;
  localparam logic [10:0] SHIFT_ONES = 11'h7ff;
  localparam logic [10:0] SHIFT_ZEROS = 11'h000;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 9;
  localparam logic [7:0] BAUD_RESET = 8'h00;

  typedef enum logic [0:0] {
    ASU_RX_IDLE = 1'b0,
    ASU_RX_FRAME = 1'b1
  } asu_rx_state_e;

  typedef struct packed {
    logic nineBit;
    logic wakeAddr;
    logic txEn;
    logic rxEn;
    logic txEmptyIrqEn;
    logic txCompleteIrqEn;
    logic rxIrqEn;
    logic idleIrqEn;
  } asu_cfg_s;

  typedef struct packed {
    logic txBufferEmpty;
    logic txComplete;
    logic rxDataFull;
    logic overrun;
    logic idleLine;
    logic noise;
    logic framing;
  } asu_status_s;

  localparam asu_status_s STATUS_RESET = 7'h60;
endpackage

/* verilog/asu_uart_core.sv */
`timescale 1ns/10ps
module asu_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW:0] next_count;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr];
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      count <= next_count;
      inReady <= next_count != DEPTH[AW:0];
      outValid <= next_count != '0;
    end
  end
endmodule

module asu_uart_core (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire asu_pkg::asu_cfg_s cfg,
  input wire logic [7:0] baudDiv,
  input wire logic sendBreak,
  input wire logic rwuSet,
  input wire logic rdClear,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [8:0] wrData,
  input wire logic rxd,
  output logic txd,
  output logic txOe,
  output logic [7:0] rxData,
  output logic rxNinth,
  output asu_pkg::asu_status_s stat,
  output logic receiver_sleep_control,
  output logic irq
);
  // shared bit rate: one 16x enable feeds both directions
  logic [7:0] baudCnt;
  logic tick16;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      baudCnt <= asu_pkg::BAUD_RESET;
      tick16 <= 1'b0;
    end else if (baudCnt >= baudDiv) begin
      baudCnt <= asu_pkg::BAUD_RESET;
      tick16 <= 1'b1;
    end else begin
      baudCnt <= baudCnt + 8'h01;
      tick16 <= 1'b0;
    end
  end

  logic [3:0] frameLen;
  assign frameLen = cfg.nineBit ? asu_pkg::FRAME_LEN_9 : asu_pkg::FRAME_LEN_8;

  // transmit side
  logic fifoValid;
  logic [8:0] fifoData;
  logic pull;
  logic bufFull;
  logic [8:0] txBuf;
  logic [3:0] txPre;
  logic txBitTick;
  logic [10:0] txShift;
  logic [3:0] txCnt;
  logic txMid;
  logic teQ;
  logic prePend;
  logic loadPre;
  logic loadBrk;
  logic loadData;
  logic txIdleTick;

  asu_fifo #(.WIDTH(asu_pkg::FIFO_WIDTH), .DEPTH(asu_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .inValid(wrValid),
    .inReady(wrReady),
    .inData(wrData),
    .outValid(fifoValid),
    .outReady(pull),
    .outData(fifoData)
  );

  assign pull = fifoValid && !bufFull;
  assign txBitTick = tick16 && (txPre == asu_pkg::TX_LAST_PHASE);
  assign loadPre = txBitTick && txCnt == 4'h0 && prePend;
  assign loadBrk = txBitTick && txCnt == 4'h0 && !prePend && cfg.txEn && sendBreak;
  assign loadData = txBitTick && txCnt == 4'h0 && !prePend && cfg.txEn && !sendBreak && bufFull;
  assign txIdleTick = txBitTick && txCnt == 4'h0 && !loadPre && !loadBrk && !loadData;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      txPre <= 4'h0;
    end else if (tick16) begin
      txPre <= txPre + 4'h1;
    end
  end

  // one character waits in the buffer while the shifter runs
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      bufFull <= 1'b0;
      txBuf <= 9'h000;
    end else if (pull) begin
      bufFull <= 1'b1;
      txBuf <= fifoData;
    end else if (loadData) begin
      bufFull <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      teQ <= 1'b0;
      prePend <= 1'b0;
    end else begin
      teQ <= cfg.txEn;
      if (cfg.txEn && !teQ) begin
        prePend <= 1'b1;
      end else if (loadPre) begin
        prePend <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      txShift <= asu_pkg::SHIFT_ONES;
      txCnt <= 4'h0;
      txd <= 1'b1;
      txMid <= 1'b0;
    end else if (txBitTick) begin
      if (txCnt != 4'h0) begin
        txd <= txShift[0];
        txShift <= {1'b1, txShift[10:1]};
        txCnt <= txCnt - 4'h1;
      end else if (loadPre) begin
        txShift <= asu_pkg::SHIFT_ONES;
        txCnt <= frameLen;
        txMid <= 1'b1;
      end else if (loadBrk) begin
        txShift <= asu_pkg::SHIFT_ZEROS;
        txCnt <= frameLen;
        txMid <= 1'b1;
      end else if (loadData) begin
        txShift <= cfg.nineBit ? {1'b1, txBuf[8], txBuf[7:0], 1'b0}
                               : {2'b11, txBuf[7:0], 1'b0};
        txCnt <= frameLen;
        txMid <= 1'b1;
      end else begin
        txd <= 1'b1;
        txMid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      txOe <= 1'b0;
    end else begin
      txOe <= cfg.txEn || txCnt != 4'h0 || txMid;
    end
  end

  // receive side: 16x sampling, phase realigned on every falling edge
  asu_pkg::asu_rx_state_e rxState;
  logic rxQ;
  logic [3:0] phase;
  logic sA;
  logic sB;
  logic fall;
  logic decide;
  logic maj;
  logic noisy;
  logic [10:0] rxShift;
  logic [3:0] rxCnt;
  logic noiseAcc;
  logic [3:0] idleCnt;
  logic idleArmed;
  logic rxDone;
  logic msb;
  logic addrWake;
  logic idleEvt;
  logic sleeping;

  assign fall = tick16 && rxQ && !rxd;
  assign decide = tick16 && !fall && phase == asu_pkg::SAMPLE_C;
  assign maj = (sA & sB) | (sA & rxd) | (sB & rxd);
  assign noisy = !((sA == sB) && (sB == rxd));
  assign rxDone = decide && rxState == asu_pkg::ASU_RX_FRAME && rxCnt == frameLen - 4'h1;
  assign msb = cfg.nineBit ? rxShift[9] : rxShift[8];
  assign addrWake = rxDone && receiver_sleep_control && cfg.wakeAddr && msb;
  assign sleeping = receiver_sleep_control && !addrWake;
  assign idleEvt = decide && rxState == asu_pkg::ASU_RX_IDLE && rxd
      && idleCnt == frameLen - 4'h1;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rxQ <= 1'b1;
      phase <= 4'h0;
      sA <= 1'b1;
      sB <= 1'b1;
    end else if (tick16) begin
      rxQ <= rxd;
      if (fall) begin
        phase <= 4'h0;
      end else begin
        phase <= phase + 4'h1;
      end
      if (phase == asu_pkg::SAMPLE_A) begin
        sA <= rxd;
      end
      if (phase == asu_pkg::SAMPLE_B) begin
        sB <= rxd;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rxState <= asu_pkg::ASU_RX_IDLE;
      rxCnt <= 4'h0;
      rxShift <= 11'h000;
      noiseAcc <= 1'b0;
    end else if (!cfg.rxEn) begin
      rxState <= asu_pkg::ASU_RX_IDLE;
      rxCnt <= 4'h0;
    end else begin
      case (rxState)
        asu_pkg::ASU_RX_IDLE: begin
          if (fall) begin
            rxState <= asu_pkg::ASU_RX_FRAME;
            rxCnt <= 4'h0;
            noiseAcc <= 1'b0;
          end
        end
        asu_pkg::ASU_RX_FRAME: begin
          if (decide) begin
            rxShift[rxCnt] <= maj;
            noiseAcc <= noiseAcc | noisy;
            rxCnt <= rxCnt + 4'h1;
            if ((rxCnt == 4'h0 && maj) || rxDone) begin
              rxState <= asu_pkg::ASU_RX_IDLE;
            end
          end
        end
        default: begin
          rxState <= asu_pkg::ASU_RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      idleCnt <= 4'h0;
    end else if (rxState != asu_pkg::ASU_RX_IDLE || !cfg.rxEn || fall) begin
      idleCnt <= 4'h0;
    end else if (decide) begin
      if (!rxd) begin
        idleCnt <= 4'h0;
      end else if (idleCnt != frameLen) begin
        idleCnt <= idleCnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      receiver_sleep_control <= 1'b0;
    end else if (rwuSet) begin
      receiver_sleep_control <= 1'b1;
    end else if (addrWake || (idleEvt && !cfg.wakeAddr)) begin
      receiver_sleep_control <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rxData <= 8'h00;
      rxNinth <= 1'b0;
    end else if (rxDone && !sleeping && (!stat.rxDataFull || rdClear)) begin
      rxData <= rxShift[8:1];
      // in eight-bit format the stop decision is being taken in this very cycle
      rxNinth <= cfg.nineBit ? rxShift[9] : maj;
    end
  end

  // flags: a hardware set in the same cycle as a clear wins, except txBufferEmpty, where the clear by pull wins
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      stat <= asu_pkg::STATUS_RESET;
      idleArmed <= 1'b0;
    end else begin
      if (pull) begin
        stat.txBufferEmpty <= 1'b0;
      end else if (!bufFull) begin
        stat.txBufferEmpty <= 1'b1;
      end
      if (txIdleTick && txMid) begin
        stat.txComplete <= 1'b1;
      end else if (pull) begin
        stat.txComplete <= 1'b0;
      end
      if (rxDone && !sleeping) begin
        if (stat.rxDataFull && !rdClear) begin
          stat.overrun <= 1'b1;
        end else begin
          stat.rxDataFull <= 1'b1;
          stat.framing <= !maj;
          stat.noise <= noiseAcc | noisy;
        end
        idleArmed <= 1'b1;
      end else if (rdClear) begin
        stat.rxDataFull <= 1'b0;
        stat.overrun <= 1'b0;
        stat.framing <= 1'b0;
        stat.noise <= 1'b0;
      end
      if (idleEvt && idleArmed && !receiver_sleep_control) begin
        stat.idleLine <= 1'b1;
        idleArmed <= 1'b0;
      end else if (rdClear) begin
        stat.idleLine <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= (stat.txBufferEmpty && cfg.txEmptyIrqEn)
          || (stat.txComplete && cfg.txCompleteIrqEn)
          || ((stat.rxDataFull || stat.overrun) && cfg.rxIrqEn)
          || (stat.idleLine && cfg.idleIrqEn);
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  chk_idle_high: assert property (
    (txCnt == 4'h0 && !txMid && $past(txCnt) == 4'h0 && $past(!txMid)) |-> txd
  ) else $error("transmit line not high while idle");

  chk_start_stop: assert property (
    loadData |=> (!txShift[0] && txShift[txCnt - 4'h1] && txCnt == frameLen)
  ) else $error("data load lacks start or stop bit");

  chk_preamble_ones: assert property (
    loadPre |=> (txShift == asu_pkg::SHIFT_ONES)
  ) else $error("preamble not all ones");

  chk_break_zeros: assert property (
    loadBrk |=> (txShift == asu_pkg::SHIFT_ZEROS && txCnt == frameLen)
  ) else $error("break not all zeros");

  chk_pin_held: assert property (
    (txCnt != 4'h0) |=> txOe
  ) else $error("transmit pin released mid character");

  chk_overrun_keep: assert property (
    (rxDone && !sleeping && stat.rxDataFull && !rdClear)
      |=> (stat.overrun && $stable(rxData))
  ) else $error("overrun did not keep old data");

  chk_rx_load: assert property (
    (rxDone && !sleeping && !stat.rxDataFull) |=> (stat.rxDataFull && rxData == $past(rxShift[8:1]))
  ) else $error("received character not stored");

  chk_wake_clear: assert property (
    (addrWake && !rwuSet) |=> !receiver_sleep_control
  ) else $error("address mark did not wake receiver");

  chk_resync_edge: assert property (
    fall |=> (phase == 4'h0)
  ) else $error("phase not realigned on falling edge");

  chk_irq_follow: assert property (
    (stat.rxDataFull && cfg.rxIrqEn) [*2] |-> irq
  ) else $error("request missing with enabled flag");

  cov_preamble: cover property (loadPre ##[1:400] loadData);
  cov_rx_char: cover property (rxDone && !sleeping && !stat.rxDataFull);
  cov_overrun: cover property (rxDone && stat.rxDataFull && !sleeping);
  cov_wake: cover property (receiver_sleep_control ##1 !receiver_sleep_control);
endmodule

/* verilog/asu_fifo_unused_note.sv */
`timescale 1ns/10ps

/* tb/asu_remote_station.sv */
`timescale 1ns/10ps
module asu_remote_station #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_sys,
  input wire logic txd,
  input wire logic txOe,
  input wire logic nineBit,
  output logic rxd
);
  logic [9:0] gotQ[$];
  logic [9:0] word;

  // line rests at the stop level between characters
  initial rxd = 1'b1;

  task automatic sendChar(input logic [8:0] d);
    logic [10:0] frame;
    frame = nineBit ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
    for (int i = 0; i < (nineBit ? 11 : 10); i++) begin
      rxd <= frame[i];
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
  endtask

  // mid-bit sampling; the stop level lands just above the data bits
  always begin
    @(negedge txd);
    if (txOe === 1'b1) begin
      repeat (BIT_CLKS / 2) @(posedge clk_sys);
      word = '0;
      for (int i = 0; i < (nineBit ? 10 : 9); i++) begin
        repeat (BIT_CLKS) @(posedge clk_sys);
        word[i] = txd;
      end
      gotQ.push_back(word);
    end
  end
endmodule

/* tb/tb_async_serial_uart_core.sv */
`timescale 1ns/10ps
module tb_async_serial_uart_core;
  localparam int BIT_CLKS = 32;
  logic clk_sys = 1'b0;
  logic nrst;
  asu_pkg::asu_cfg_s cfg;
  logic [7:0] baudDiv;
  logic sendBreak, rwuSet, rdClear, wrValid, wrReady;
  logic [8:0] wrData;
  logic rxd, txd, txOe, rxNinth, receiver_sleep_control, irq;
  logic [7:0] rxData;
  asu_pkg::asu_status_s stat;
  int bad_count = 0;
  int compares = 0;
  int seed = 32'hd677;
  int n;
  logic [9:0] txExp[$];
  logic [8:0] b;

  always #50 clk_sys = ~clk_sys;

  asu_uart_core DUT (.clk_sys(clk_sys), .nrst(nrst), .cfg(cfg), .baudDiv(baudDiv),
    .sendBreak(sendBreak), .rwuSet(rwuSet), .rdClear(rdClear), .wrValid(wrValid),
    .wrReady(wrReady), .wrData(wrData), .rxd(rxd), .txd(txd), .txOe(txOe),
    .rxData(rxData), .rxNinth(rxNinth), .stat(stat), .receiver_sleep_control(receiver_sleep_control), .irq(irq));

  asu_remote_station #(.BIT_CLKS(BIT_CLKS)) peer (.clk_sys(clk_sys), .txd(txd),
    .txOe(txOe), .nineBit(cfg.nineBit), .rxd(rxd));

  task automatic report_and_stop;
    $display("mismatches %0d, compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  function automatic logic cond(input int sel);
    case (sel)
      0: return stat.rxDataFull;
      1: return stat.txComplete;
      2: return stat.idleLine;
      3: return !receiver_sleep_control;
      4: return !txd;
      default: return peer.gotQ.size() != 0;
    endcase
  endfunction

  // bounded wait, sampled between edges, returns on a rising edge
  task automatic waitOn(input int sel, input int lim, output int cnt);
    cnt = 0;
    @(negedge clk_sys);
    while (cond(sel) !== 1'b1) begin
      if (cnt == lim) begin
        bad_count++;
        report_and_stop();
      end
      cnt++;
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
  endtask

  task automatic pulse(input int sel);
    if (sel == 0) rdClear <= 1'b1;
    else rwuSet <= 1'b1;
    @(posedge clk_sys);
    rdClear <= 1'b0;
    rwuSet <= 1'b0;
  endtask

  task automatic pushWord(input logic [8:0] d);
    wrData <= d;
    wrValid <= 1'b1;
    txExp.push_back(cfg.nineBit ? {1'b1, d} : {2'b01, d[7:0]});
    @(posedge clk_sys);
    wrValid <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic drain(input int cnt);
    repeat (cnt) begin
      waitOn(5, 25 * BIT_CLKS, n);
      check(peer.gotQ.pop_front(), txExp.pop_front());
    end
  endtask

  task automatic irqCase(input logic tce, input logic tee, input logic want);
    @(posedge clk_sys);
    cfg.txCompleteIrqEn <= tce;
    cfg.txEmptyIrqEn <= tee;
    repeat (3) @(negedge clk_sys);
    check(10'(irq), 10'(want));
  endtask

  initial begin
    nrst = 1'b0;
    cfg = '0;
    baudDiv = 8'h01;
    sendBreak = 1'b0;
    rwuSet = 1'b0;
    rdClear = 1'b0;
    wrValid = 1'b0;
    wrData = '0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    check(10'(stat), 10'(asu_pkg::STATUS_RESET));
    check(10'({txd, txOe, receiver_sleep_control, irq, wrReady}), 10'h011);
    // fill with the transmitter off until writes are refused
    @(posedge clk_sys);
    wrData <= 9'($random(seed));
    wrValid <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_sys);
      if (wrReady === 1'b1)
        txExp.push_back({2'b01, wrData[7:0]});
      @(posedge clk_sys);
      wrData <= 9'($random(seed));
    end
    wrValid <= 1'b0;
    @(negedge clk_sys);
    check(10'(txExp.size()), 10'(asu_pkg::FIFO_DEPTH + 1));
    check(10'(wrReady), 10'h000);
    @(posedge clk_sys);
    cfg.txEn <= 1'b1;
    cfg.txCompleteIrqEn <= 1'b1;
    waitOn(4, 20 * BIT_CLKS, n);
    check(10'(n >= 10 * BIT_CLKS), 10'h001);
    drain(txExp.size());
    waitOn(1, 4 * BIT_CLKS, n);
    @(negedge clk_sys);
    check(10'({stat.txBufferEmpty, stat.txComplete, irq}), 10'h007);
    irqCase(1'b0, 1'b1, 1'b1);
    irqCase(1'b0, 1'b0, 1'b0);
    n = $random(seed);
    irqCase(n[0], n[1], n[0] | n[1]);
    // nine-bit characters, then drop the enable mid-character
    @(posedge clk_sys);
    cfg.nineBit <= 1'b1;
    @(posedge clk_sys);
    pushWord(9'h1a5);
    pushWord(9'h05a);
    pushWord(9'($random(seed)));
    drain(2);
    waitOn(4, 12 * BIT_CLKS, n);
    cfg.txEn <= 1'b0;
    @(negedge clk_sys);
    check(10'(txOe), 10'h001);
    drain(1);
    repeat (BIT_CLKS) @(negedge clk_sys);
    check(10'({txOe, txd}), 10'h001);
    @(posedge clk_sys);
    cfg.txEn <= 1'b1;
    sendBreak <= 1'b1;
    waitOn(5, 30 * BIT_CLKS, n);
    check(peer.gotQ.pop_front(), 10'h000);
    sendBreak <= 1'b0;
    waitOn(1, 30 * BIT_CLKS, n);
    cfg.txEn <= 1'b0;
    cfg.rxEn <= 1'b1;
    cfg.rxIrqEn <= 1'b1;
    // receive in both lengths; eight-bit mode reports the stop level as ninth
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys);
      cfg.nineBit <= m[0];
      for (int i = 0; i < 3; i++) begin
        @(posedge clk_sys);
        b = 9'($random(seed));
        peer.sendChar(b);
        waitOn(0, 2 * BIT_CLKS, n);
        @(negedge clk_sys);
        check({1'b0, rxNinth, rxData}, m ? {1'b0, b} : {2'b01, b[7:0]});
        check(10'(irq), 10'h001);
        check(10'({stat.noise, stat.framing}), 10'h000);
        @(posedge clk_sys);
        pulse(0);
      end
    end
    peer.sendChar(9'h0c3);
    peer.sendChar(9'h13c);
    @(negedge clk_sys);
    check({1'b0, stat.overrun, rxData}, 10'h1c3);
    @(posedge clk_sys);
    pulse(0);
    cfg.rxIrqEn <= 1'b0;
    cfg.idleIrqEn <= 1'b1;
    peer.sendChar(9'h0f0);
    waitOn(2, 14 * BIT_CLKS, n);
    @(negedge clk_sys);
    check(10'(irq), 10'h001);
    @(posedge clk_sys);
    pulse(0);
    cfg.idleIrqEn <= 1'b0;
    cfg.wakeAddr <= 1'b1;
    @(posedge clk_sys);
    pulse(1);
    @(negedge clk_sys);
    check(10'(receiver_sleep_control), 10'h001);
    @(posedge clk_sys);
    peer.sendChar(9'h055);
    @(negedge clk_sys);
    check(10'({stat.rxDataFull, receiver_sleep_control}), 10'h001);
    @(posedge clk_sys);
    peer.sendChar(9'h1aa);
    waitOn(0, 2 * BIT_CLKS, n);
    @(negedge clk_sys);
    check({receiver_sleep_control, rxNinth, rxData}, 10'h1aa);
    @(posedge clk_sys);
    pulse(0);
    cfg.wakeAddr <= 1'b0;
    fork
      peer.sendChar(9'h012);
      begin
        repeat (2 * BIT_CLKS) @(posedge clk_sys);
        pulse(1);
      end
    join
    @(negedge clk_sys);
    check(10'({stat.rxDataFull, receiver_sleep_control}), 10'h001);
    waitOn(3, 13 * BIT_CLKS, n);
    check(10'(n > 9 * BIT_CLKS), 10'h001);
    report_and_stop();
  end
endmodule
